/* common/oad_pkg.sv */
// Shared constants and types for the operand address decoder
`default_nettype none
package oad_pkg;
    // Instruction byte values
    localparam logic [7:0] BYTE_ESCAPE    = 8'h0f;
    localparam logic [7:0] BYTE_RAISE_RPL = 8'h63;
    localparam logic [7:0] ESC2_GROUP0    = 8'h00;
    localparam logic [7:0] ESC2_GROUP1    = 8'h01;
    localparam logic [7:0] ESC2_ACCESS    = 8'h02;
    localparam logic [7:0] ESC2_LIMIT     = 8'h03;
    // Prefix pattern 001 sr 110
    localparam logic [2:0] PFX_HI         = 3'h1;
    localparam logic [2:0] PFX_LO         = 3'h6;
    // Addressing-kind values
    localparam logic [1:0] MOD_NODISP     = 2'h0;
    localparam logic [1:0] MOD_DISP8      = 2'h1;
    localparam logic [1:0] MOD_DISP16     = 2'h2;
    localparam logic [1:0] MOD_REG        = 2'h3;
    localparam logic [2:0] RM_DIRECT     = 3'h6;
    // Middle-field values
    localparam logic [2:0] MID_SAVE_TASK  = 3'h1;
    localparam logic [2:0] MID_LOAD_TASK  = 3'h3;
    localparam logic [2:0] MID_CHK_READ   = 3'h4;
    localparam logic [2:0] MID_CHK_WRITE  = 3'h5;
    localparam logic [2:0] MID_SAVE_MSW   = 3'h4;
    localparam logic [2:0] MID_LOAD_MSW   = 3'h6;
    // Segment codes
    localparam logic [1:0] SEG_EXTRA      = 2'h0;
    localparam logic [1:0] SEG_CODE       = 2'h1;
    localparam logic [1:0] SEG_STACK      = 2'h2;
    localparam logic [1:0] SEG_DATA       = 2'h3;
    // Clock costs, register form then memory form
    localparam logic [4:0] CLK_LTS_R = 5'h11;
    localparam logic [4:0] CLK_LTS_M = 5'h13;
    localparam logic [4:0] CLK_STS_R = 5'h02;
    localparam logic [4:0] CLK_STS_M = 5'h03;
    localparam logic [4:0] CLK_LMW_R = 5'h03;
    localparam logic [4:0] CLK_LMW_M = 5'h06;
    localparam logic [4:0] CLK_SMW_R = 5'h02;
    localparam logic [4:0] CLK_SMW_M = 5'h03;
    localparam logic [4:0] CLK_FAR_R = 5'h0e;
    localparam logic [4:0] CLK_FAR_M = 5'h10;
    localparam logic [4:0] CLK_FSL_R = 5'h0e;
    localparam logic [4:0] CLK_FSL_M = 5'h12;
    localparam logic [4:0] CLK_RRP_R = 5'h0a;
    localparam logic [4:0] CLK_RRP_M = 5'h0b;
    localparam logic [4:0] CLK_CHK_R = 5'h0e;
    localparam logic [4:0] CLK_CHK_M = 5'h10;
    localparam logic [4:0] CLK_NONE  = 5'h00;

    typedef enum logic [3:0] {
        OP_GENERIC = 4'h0, OP_LTS = 4'h1, OP_STS = 4'h2, OP_LMW = 4'h3,
        OP_SMW = 4'h4, OP_FAR = 4'h5, OP_FSL = 4'h6, OP_RRP = 4'h7,
        OP_CHR = 4'h8, OP_CHW = 4'h9, OP_BAD = 4'ha
    } oad_op_t;

    typedef enum logic [3:0] {
        R_ACCUM_WORD = 4'h0, R_COUNT_WORD = 4'h1, R_AUX_WORD = 4'h2,
        R_BASE_WORD = 4'h3, R_STACK_TOP = 4'h4, R_FRAME_BASE = 4'h5,
        R_SOURCE_INDEX = 4'h6, R_DEST_INDEX = 4'h7, R_ACCUM_LOW = 4'h8,
        R_COUNT_LOW = 4'h9, R_AUX_LOW = 4'ha, R_BASE_LOW = 4'hb,
        R_ACCUM_HIGH = 4'hc, R_COUNT_HIGH = 4'hd, R_AUX_HIGH = 4'he,
        R_BASE_HIGH = 4'hf
    } oad_reg_t;

    typedef struct packed {
        logic [15:0] base_word;
        logic [15:0] frame_base_pointer;
        logic [15:0] source_index;
        logic [15:0] dest_index;
    } oad_regs_t;

    typedef struct packed {
        oad_op_t     op;
        logic        is_reg;
        oad_reg_t    reg_id;
        logic [15:0] effective_location;
        logic [15:0] disp;
        logic [1:0]  seg;
        logic [4:0]  clocks;
        logic        invalid;
    } oad_result_t;
endpackage
`default_nettype wire

/* src/oad_ea.sv */
// Effective location adder and default segment
`default_nettype none
module oad_ea (
    // Addressing fields
    input  wire logic [1:0]        mod_i,
    input  wire logic [2:0]        rm_i,
    input  wire logic [15:0]       disp_i,
    input  wire oad_pkg::oad_regs_t regs_i,
    // Result
    output logic [15:0]            ea_o,
    output logic                   frame_o
);
    import oad_pkg::*;

    logic [15:0] base;

    always_comb begin
        base    = 16'h0000;
        frame_o = 1'b0;
        case (rm_i)
            3'h0: base = regs_i.base_word + regs_i.source_index;
            3'h1: base = regs_i.base_word + regs_i.dest_index;
            3'h2: begin
                base    = regs_i.frame_base_pointer + regs_i.source_index;
                frame_o = 1'b1;
            end
            3'h3: begin
                base    = regs_i.frame_base_pointer + regs_i.dest_index;
                frame_o = 1'b1;
            end
            3'h4: base = regs_i.source_index;
            3'h5: base = regs_i.dest_index;
            3'h6: begin
                base    = regs_i.frame_base_pointer;
                frame_o = 1'b1;
            end
            default: base = regs_i.base_word;
        endcase
        if (mod_i == MOD_NODISP && rm_i == RM_DIRECT) begin
            base    = 16'h0000;
            frame_o = 1'b0;
        end
        ea_o = base + disp_i;
    end
endmodule // oad_ea
`default_nettype wire

/* src/oad_regmap.sv */
// Register code to register identity mapping
`default_nettype none
module oad_regmap (
    // Encoding
    input  wire logic             wide_i,
    input  wire logic [2:0]       code_i,
    // Identity
    output var  oad_pkg::oad_reg_t reg_o
);
    import oad_pkg::*;

    always_comb begin
        reg_o = oad_reg_t'({~wide_i, code_i});
    end
endmodule // oad_regmap
`default_nettype wire

/* src/oad_top.sv */
// Operand addressing and protection-opcode decoder
`default_nettype none

// Functional notes
// - Kind 11 means operand is a register
// - Kind 00: zero displacement, no bytes fetched
// - Kind 01: one byte, sign-extended
// - Kind 10: two bytes, low first
// - Codes 000-011 pair base with index
// - Codes 100-111 use single base or index register
// - Kind 00 code 110 is direct address
// - Displacement directly after addressing byte, before immediates
// - Override code picks extra/code/stack/data segment
// - Register code maps word and byte registers
// - Frame-based operands default to stack segment
// - String destination always uses extra segment
// - Recognise load task selector, 17/19 clocks
// - Recognise save task selector, 2/3 clocks
// - Recognise load machine word, 3/6 clocks
// - Recognise save machine word, 2/3 clocks
// - Recognise fetch access rights, 14/16 clocks
// - Recognise fetch segment limit, 14/18 clocks
// - Recognise raise requested privilege, 10/11
// - Recognise check readable, 14/16 clocks
// - Recognise check writable, 14/16 clocks
module oad_top (
    // Clock and reset
    input  wire logic               CLK_I,
    input  wire logic               SYS_RST_I,
    input  wire logic               CE_I,
    // Instruction byte stream
    input  wire logic [7:0]         BYTE_I,
    input  wire logic               BYTE_VALID_I,
    output logic                    BYTE_READY_O,
    // Processor context
    input  wire logic               PROT_MODE_I,
    input  wire logic               STR_DEST_I,
    input  wire oad_pkg::oad_regs_t REGS_I,
    // Decode result
    output logic                    DONE_O,
    output oad_pkg::oad_result_t    RESULT_O
);
    import oad_pkg::*;

    typedef enum logic [2:0] {
        S_OPCODE = 3'b000,
        S_ESCAPE = 3'b001,
        S_MODRM  = 3'b010,
        S_DLO    = 3'b011,
        S_DHI    = 3'b100,
        S_DONE   = 3'b101
    } oad_state_t;

    oad_state_t  state_reg;
    oad_state_t  state_next;
    oad_op_t     op_reg;
    oad_op_t     op_next;
    logic [1:0]  grp_reg;
    logic [1:0]  grp_next;
    logic        wide_reg;
    logic [1:0]  mod_reg;
    logic [2:0]  mid_reg;
    logic [2:0]  rm_reg;
    logic [7:0]  dlo_reg;
    logic [7:0]  dhi_reg;
    logic        ovr_valid_reg;
    logic [1:0]  ovr_seg_reg;
    logic        take;

    logic [15:0] disp;
    logic [15:0] ea;
    logic        frame;
    oad_reg_t    reg_id;
    logic [1:0]  seg;
    logic [4:0]  cost;
    logic        bad;

    // Escape groups
    localparam logic [1:0] GRP_NONE = 2'h0;
    localparam logic [1:0] GRP_ZERO = 2'h1;
    localparam logic [1:0] GRP_ONE  = 2'h2;

    assign take = CE_I && BYTE_READY_O && BYTE_VALID_I;

    // Group member chosen by middle field
    function automatic oad_op_t group_op(input logic [1:0] grp,
                                         input logic [2:0] mid,
                                         input oad_op_t    cur);
        group_op = cur;
        if (grp == GRP_ZERO) begin
            if (mid == MID_LOAD_TASK) begin
                group_op = OP_LTS;
            end else if (mid == MID_SAVE_TASK) begin
                group_op = OP_STS;
            end else if (mid == MID_CHK_READ) begin
                group_op = OP_CHR;
            end else if (mid == MID_CHK_WRITE) begin
                group_op = OP_CHW;
            end else begin
                group_op = OP_GENERIC;
            end
        end else if (grp == GRP_ONE) begin
            if (mid == MID_LOAD_MSW) begin
                group_op = OP_LMW;
            end else if (mid == MID_SAVE_MSW) begin
                group_op = OP_SMW;
            end else begin
                group_op = OP_GENERIC;
            end
        end
    endfunction

    // Pick register or memory cost
    function automatic logic [4:0] pick(input logic       is_reg,
                                        input logic [4:0] r,
                                        input logic [4:0] m);
        pick = is_reg ? r : m;
    endfunction

    // How many displacement bytes follow the addressing byte
    function automatic logic [1:0] disp_count(input logic [1:0] md,
                                              input logic [2:0] rm);
        disp_count = 2'h0;
        if (md == MOD_DISP8) begin
            disp_count = 2'h1;
        end else if (md == MOD_DISP16) begin
            disp_count = 2'h2;
        end else if (md == MOD_NODISP && rm == RM_DIRECT) begin
            disp_count = 2'h2;
        end
    endfunction

    // Sequencing of instruction bytes
    always_comb begin
        state_next = state_reg;
        op_next    = op_reg;
        grp_next   = grp_reg;
        case (state_reg)
            S_OPCODE: begin
                if (take) begin
                    if (BYTE_I[7:5] == PFX_HI && BYTE_I[2:0] == PFX_LO) begin
                        state_next = S_OPCODE;
                    end else if (BYTE_I == BYTE_ESCAPE) begin
                        state_next = S_ESCAPE;
                    end else if (BYTE_I == BYTE_RAISE_RPL) begin
                        op_next    = OP_RRP;
                        grp_next   = GRP_NONE;
                        state_next = S_MODRM;
                    end else begin
                        op_next    = OP_GENERIC;
                        grp_next   = GRP_NONE;
                        state_next = S_MODRM;
                    end
                end
            end
            S_ESCAPE: begin
                if (take) begin
                    state_next = S_MODRM;
                    grp_next   = GRP_NONE;
                    op_next    = OP_GENERIC;
                    if (BYTE_I == ESC2_GROUP0) begin
                        grp_next = GRP_ZERO;
                    end else if (BYTE_I == ESC2_GROUP1) begin
                        grp_next = GRP_ONE;
                    end else if (BYTE_I == ESC2_ACCESS) begin
                        op_next = OP_FAR;
                    end else if (BYTE_I == ESC2_LIMIT) begin
                        op_next = OP_FSL;
                    end else begin
                        op_next    = OP_BAD;
                        state_next = S_DONE;
                    end
                end
            end
            S_MODRM: begin
                if (take) begin
                    op_next = group_op(grp_reg, BYTE_I[5:3], op_reg);
                    // Displacement directly after addressing byte
                    if (disp_count(BYTE_I[7:6], BYTE_I[2:0]) == 2'h0) begin
                        state_next = S_DONE;
                    end else begin
                        state_next = S_DLO;
                    end
                end
            end
            S_DLO: begin
                if (take) begin
                    if (disp_count(mod_reg, rm_reg) == 2'h1) begin
                        state_next = S_DONE;
                    end else begin
                        state_next = S_DHI;
                    end
                end
            end
            S_DHI: begin
                if (take) begin
                    state_next = S_DONE;
                end
            end
            default: begin
                if (CE_I) begin
                    state_next = S_OPCODE;
                end
            end
        endcase
    end

    // State and stream handshake
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            state_reg    <= S_OPCODE;
            op_reg       <= OP_GENERIC;
            grp_reg      <= GRP_NONE;
            BYTE_READY_O <= 1'b1;
        end else if (CE_I) begin
            state_reg    <= state_next;
            op_reg       <= op_next;
            grp_reg      <= grp_next;
            BYTE_READY_O <= (state_next != S_DONE);
        end
    end

    // Captured instruction fields
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            wide_reg <= 1'b1;
            mod_reg  <= MOD_NODISP;
            mid_reg  <= 3'h0;
            rm_reg   <= 3'h0;
            dlo_reg  <= 8'h00;
            dhi_reg  <= 8'h00;
        end else if (take) begin
            if (state_reg == S_OPCODE) begin
                wide_reg <= (BYTE_I == BYTE_RAISE_RPL) | BYTE_I[0];
                dlo_reg  <= 8'h00;
                dhi_reg  <= 8'h00;
            end else if (state_reg == S_ESCAPE) begin
                wide_reg <= 1'b1;
                mod_reg  <= MOD_REG;
            end else if (state_reg == S_MODRM) begin
                mod_reg <= BYTE_I[7:6];
                mid_reg <= BYTE_I[5:3];
                rm_reg  <= BYTE_I[2:0];
            end else if (state_reg == S_DLO) begin
                dlo_reg <= BYTE_I;
            end else if (state_reg == S_DHI) begin
                dhi_reg <= BYTE_I;
            end
        end
    end

    // Segment override prefix
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            ovr_valid_reg <= 1'b0;
            ovr_seg_reg   <= SEG_DATA;
        end else if (CE_I) begin
            if (state_reg == S_DONE) begin
                ovr_valid_reg <= 1'b0;
            end else if (take && state_reg == S_OPCODE &&
                         BYTE_I[7:5] == PFX_HI && BYTE_I[2:0] == PFX_LO) begin
                ovr_valid_reg <= 1'b1;
                ovr_seg_reg   <= BYTE_I[4:3];
            end
        end
    end

    // Displacement formation
    always_comb begin
        disp = 16'h0000;
        if (disp_count(mod_reg, rm_reg) == 2'h1) begin
            disp = {{8{dlo_reg[7]}}, dlo_reg};
        end else if (disp_count(mod_reg, rm_reg) == 2'h2) begin
            disp = {dhi_reg, dlo_reg};
        end
    end

    oad_ea u_ea (
        .mod_i   (mod_reg),
        .rm_i    (rm_reg),
        .disp_i  (disp),
        .regs_i  (REGS_I),
        .ea_o    (ea),
        .frame_o (frame)
    );

    oad_regmap u_regmap (
        .wide_i (wide_reg),
        .code_i (rm_reg),
        .reg_o  (reg_id)
    );

    // Segment selection
    always_comb begin
        if (STR_DEST_I) begin
            seg = SEG_EXTRA;
        end else if (ovr_valid_reg) begin
            seg = ovr_seg_reg;
        end else if (frame) begin
            seg = SEG_STACK;
        end else begin
            seg = SEG_DATA;
        end
    end

    // Clock cost and mode legality
    always_comb begin
        logic is_reg;
        is_reg = (mod_reg == MOD_REG);
        cost   = CLK_NONE;
        bad    = 1'b0;
        case (op_reg)
            OP_LTS: cost = pick(is_reg, CLK_LTS_R, CLK_LTS_M);
            OP_STS: cost = pick(is_reg, CLK_STS_R, CLK_STS_M);
            OP_LMW: cost = pick(is_reg, CLK_LMW_R, CLK_LMW_M);
            OP_SMW: cost = pick(is_reg, CLK_SMW_R, CLK_SMW_M);
            OP_FAR: cost = pick(is_reg, CLK_FAR_R, CLK_FAR_M);
            OP_FSL: cost = pick(is_reg, CLK_FSL_R, CLK_FSL_M);
            OP_RRP: cost = pick(is_reg, CLK_RRP_R, CLK_RRP_M);
            OP_CHR: cost = pick(is_reg, CLK_CHK_R, CLK_CHK_M);
            OP_CHW: cost = pick(is_reg, CLK_CHK_R, CLK_CHK_M);
            OP_BAD: bad = 1'b1;
            default: cost = CLK_NONE;
        endcase
        // Only generic ops and the machine-word pair run in real mode
        if (!PROT_MODE_I && op_reg != OP_GENERIC && op_reg != OP_LMW &&
            op_reg != OP_SMW) begin
            bad = 1'b1;
        end
        if (bad) begin
            cost = CLK_NONE;
        end
    end

    // Result register
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            DONE_O   <= 1'b0;
            RESULT_O <= '0;
        end else if (CE_I) begin
            DONE_O <= (state_reg == S_DONE);
            if (state_reg == S_DONE) begin
                RESULT_O.op      <= op_reg;
                RESULT_O.is_reg  <= (mod_reg == MOD_REG);
                RESULT_O.reg_id  <= reg_id;
                RESULT_O.disp    <= disp;
                RESULT_O.seg     <= seg;
                RESULT_O.clocks  <= cost;
                RESULT_O.invalid <= bad;
                if (mod_reg == MOD_REG) begin
                    RESULT_O.effective_location <= 16'h0000;
                end else begin
                    RESULT_O.effective_location <= ea;
                end
            end
        end
    end
endmodule // oad_top
`default_nettype wire

/* tb/oad_fetch_model.sv */
// Behavioural instruction fetch queue feeding the decoder
`default_nettype none
module oad_fetch_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // Loading and pacing
    input  wire logic       push_i,
    input  wire logic [7:0] push_byte_i,
    input  wire logic       slow_i,
    // Byte stream
    input  wire logic       ready_i,
    output logic [7:0]      byte_o,
    output logic            valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q[$];
    logic [7:0] last = 8'h00;
    logic       gap = 1'b0;
    initial begin
        byte_o = 8'hff;
        valid_o = 1'b0;
    end
    always @(posedge clk_i) begin
        gap = 1'b0;
        if (rst_i) begin
            q.delete();
        end else begin
            if (ce_i && valid_o && ready_i) begin
                last = q.pop_front();
                gap = slow_i;
            end
            if (push_i) q.push_back(push_byte_i);
        end
        #1;
        valid_o = (q.size() != 0) && !gap;
        // Idle line shows no stale byte
        byte_o = valid_o ? q[0] : ~last;
    end
endmodule // oad_fetch_model
`default_nettype wire

/* tb/oad_top_assertions.sv */
// Result and handshake checks on the decoder ports
`default_nettype none
module oad_top_chk import oad_pkg::*; (
    // Clock and reset
    input wire logic                 CLK_I,
    input wire logic                 SYS_RST_I,
    input wire logic                 CE_I,
    // Byte stream
    input wire logic [7:0]           BYTE_I,
    input wire logic                 BYTE_VALID_I,
    input wire logic                 BYTE_READY_O,
    // Context and result
    input wire logic                 PROT_MODE_I,
    input wire logic                 STR_DEST_I,
    input wire oad_pkg::oad_regs_t   REGS_I,
    input wire logic                 DONE_O,
    input wire oad_pkg::oad_result_t RESULT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    function automatic logic [4:0] cost(oad_op_t o, logic r);
        case (o)
            OP_LTS: cost = r ? 5'h11 : 5'h13;
            OP_STS, OP_SMW: cost = r ? 5'h02 : 5'h03;
            OP_LMW: cost = r ? 5'h03 : 5'h06;
            OP_FAR, OP_CHR, OP_CHW: cost = r ? 5'h0e : 5'h10;
            OP_FSL: cost = r ? 5'h0e : 5'h12;
            OP_RRP: cost = r ? 5'h0a : 5'h0b;
            default: cost = 5'h00;
        endcase
    endfunction
    AST_REG_NO_ADDR: assert property (DONE_O && RESULT_O.is_reg |->
        RESULT_O.effective_location == 16'h0 && RESULT_O.disp == 16'h0)
        else $error("register carries address");
    AST_PROT_WORD: assert property (DONE_O && RESULT_O.is_reg &&
        RESULT_O.op != OP_GENERIC |-> !RESULT_O.reg_id[3])
        else $error("protect op not word reg");
    AST_STR_EXTRA: assert property (DONE_O && !RESULT_O.is_reg &&
        $past(CE_I) && $past(STR_DEST_I) |-> RESULT_O.seg == SEG_EXTRA)
        else $error("string dest not extra");
    AST_REAL_REJECT: assert property (DONE_O && $past(CE_I) &&
        !$past(PROT_MODE_I) && RESULT_O.op inside {OP_LTS, OP_STS,
        OP_FAR, OP_FSL, OP_RRP, OP_CHR, OP_CHW} |-> RESULT_O.invalid)
        else $error("real mode not refused");
    AST_INVALID_FREE: assert property (DONE_O && RESULT_O.invalid
        |-> RESULT_O.clocks == CLK_NONE)
        else $error("invalid op has cost");
    AST_MSW_REAL: assert property (DONE_O &&
        RESULT_O.op inside {OP_LMW, OP_SMW} |-> !RESULT_O.invalid)
        else $error("msw op refused");
    AST_COST: assert property (DONE_O && !RESULT_O.invalid |->
        RESULT_O.clocks == cost(RESULT_O.op, RESULT_O.is_reg))
        else $error("clock cost wrong");
    AST_READY_GAP: assert property (!BYTE_READY_O && CE_I
        |=> BYTE_READY_O ##0 DONE_O)
        else $error("gap without done");
    AST_DONE_CAUSE: assert property (DONE_O && $past(CE_I)
        |-> !$past(BYTE_READY_O))
        else $error("done without gap");
endmodule // oad_top_chk
`default_nettype wire

/* tb/operand_address_decode_tb_top.sv */
// Self-checking bench for the operand address decoder
`default_nettype none
module operand_address_decode_tb_top import oad_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] BXV = 16'h1000;
    localparam logic [15:0] BPV = 16'h2000;
    localparam logic [15:0] SIV = 16'h0300;
    localparam logic [15:0] DIV = 16'h0040;
    // Second byte, middle, op, register cost, memory cost, real ok
    localparam logic [39:0] TBL [9] = '{
        40'h00_3_1_11_13_00, 40'h00_1_2_02_03_00, 40'h01_6_3_03_06_01,
        40'h01_4_4_02_03_01, 40'h02_0_5_0e_10_00, 40'h03_0_6_0e_12_00,
        40'h63_0_7_0a_0b_00, 40'h00_4_8_0e_10_00, 40'h00_5_9_0e_10_00};
    logic        clk, rst, ce, prot, str_dest, push, slow, fv, ready, done;
    logic [7:0]  push_byte, fb;
    oad_regs_t   regs;
    oad_result_t rslt, res;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cyc = 0;

    oad_fetch_model fm_u (.clk_i(clk), .rst_i(rst), .ce_i(ce),
        .push_i(push), .push_byte_i(push_byte), .slow_i(slow),
        .ready_i(ready), .byte_o(fb), .valid_o(fv));
    oad_top dut_u (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .BYTE_I(fb),
        .BYTE_VALID_I(fv), .BYTE_READY_O(ready), .PROT_MODE_I(prot),
        .STR_DEST_I(str_dest), .REGS_I(regs), .DONE_O(done),
        .RESULT_O(rslt));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_of_test;
        $display("checks %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            end_of_test;
        end
    end

    task automatic chk(input string nm, input logic [63:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [15:0] ea(logic [2:0] rm, logic [15:0] d);
        case (rm)
            3'h0: ea = BXV + SIV + d;
            3'h1: ea = BXV + DIV + d;
            3'h2: ea = BPV + SIV + d;
            3'h3: ea = BPV + DIV + d;
            3'h4: ea = SIV + d;
            3'h5: ea = DIV + d;
            3'h6: ea = BPV + d;
            default: ea = BXV + d;
        endcase
    endfunction

    task automatic push_bytes(input logic [39:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            push = 1'b1;
            push_byte = b[39-8*i -: 8];
            @(posedge clk);
            #1;
        end
        push = 1'b0;
    endtask

    task automatic wait_done;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            #1;
            if (done === 1'b1) begin
                res = rslt;
                return;
            end
        end
        chk("done", 0, 1);
    endtask

    task automatic go(input logic [39:0] b, input int n);
        push_bytes(b, n);
        wait_done;
    endtask

    task automatic t_regs;
        for (int w = 0; w < 2; w++)
            for (int c = 0; c < 8; c++) begin
                go({7'h45, w[0], 2'b11, 3'h0, c[2:0], 24'h0}, 2);
                chk("is_reg", res.is_reg, 1);
                chk("reg_id", res.reg_id, {~w[0], c[2:0]});
            end
        $display("test regs done");
    endtask

    task automatic t_mem;
        logic [15:0] d, e;
        logic [1:0]  s;
        logic        dir;
        for (int m = 0; m < 3; m++)
            for (int k = 0; k < 8; k++) begin
                dir = (m == 0 && k == 6);
                d = (m == 1) ? 16'hff80 : (m == 2) ? 16'h1280 : 16'h0;
                e = dir ? 16'h1280 : ea(k[2:0], d);
                s = (k inside {2, 3, 6} && !dir) ? SEG_STACK : SEG_DATA;
                go({8'h8b, m[1:0], 3'h0, k[2:0], 16'h8012, 8'h0},
                   dir ? 4 : m + 2);
                chk("ea", res.effective_location, e);
                chk("seg", res.seg, s);
                if (!dir) chk("disp", res.disp, d);
            end
        $display("test memory done");
    endtask

    task automatic t_ovr;
        logic [1:0] sr;
        for (int s = 0; s < 5; s++) begin
            str_dest = (s == 4);
            sr = (s == 4) ? SEG_CODE : s[1:0];
            go({3'h1, sr, 3'h6, 8'h8b, 8'h05, 16'h0}, 3);
            chk("seg", res.seg, str_dest ? SEG_EXTRA : sr);
        end
        str_dest = 1'b0;
        $display("test override done");
    endtask

    task automatic t_prot;
        logic [39:0] t;
        logic [7:0]  mr;
        logic        bad;
        for (int i = 0; i < 9; i++)
            for (int f = 0; f < 4; f++) begin
                t = TBL[i];
                prot = f[1];
                mr = {f[0] ? 2'b11 : 2'b00, t[30:28], 3'h4};
                if (t[39:32] == 8'h63) go({8'h63, mr, 24'h0}, 2);
                else go({8'h0f, t[39:32], mr, 16'h0}, 3);
                bad = !prot && !t[0];
                chk("op", res.op, t[27:24]);
                chk("invalid", res.invalid, bad);
                chk("clocks", res.clocks,
                    bad ? 8'h0 : f[0] ? t[23:16] : t[15:8]);
            end
        go({8'h0f, 8'h07, 24'h0}, 2);
        chk("bad op", res.invalid, 1);
        prot = 1'b1;
        $display("test protection done");
    endtask

    task automatic t_stall;
        slow = 1'b1;
        push_bytes({8'h0f, 8'h00, 8'h9e, 8'h80, 8'h12}, 5);
        ce = 1'b0;
        repeat (3) @(posedge clk);
        #1 ce = 1'b1;
        wait_done;
        slow = 1'b0;
        chk("ea", res.effective_location, BPV + 16'h1280);
        chk("seg", res.seg, SEG_STACK);
        chk("clocks", res.clocks, 5'h13);
        $display("test stall done");
    endtask

    task automatic t_reset;
        push_bytes({8'h0f, 8'h00, 24'h0}, 2);
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        chk("ready", ready, 1);
        chk("done", done, 0);
        chk("result", rslt, 0);
        $display("test reset done");
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        prot = 1'b1;
        str_dest = 1'b0;
        push = 1'b0;
        slow = 1'b0;
        push_byte = 8'h00;
        regs = '{BXV, BPV, SIV, DIV};
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        t_regs;
        t_mem;
        t_ovr;
        t_prot;
        t_stall;
        t_reset;
        end_of_test;
    end
endmodule // operand_address_decode_tb_top

bind oad_top oad_top_chk chk_u (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .CE_I(CE_I), .BYTE_I(BYTE_I), .BYTE_VALID_I(BYTE_VALID_I),
    .BYTE_READY_O(BYTE_READY_O), .PROT_MODE_I(PROT_MODE_I),
    .STR_DEST_I(STR_DEST_I), .REGS_I(REGS_I), .DONE_O(DONE_O),
    .RESULT_O(RESULT_O));
`default_nettype wire
